//--- rtl/rst_init_defs.svh
`ifndef RST_INIT_DEFS_SVH
`define RST_INIT_DEFS_SVH

// Timing of the reset input filter.
`define CLK_PERIOD_NS        20
`define FILTER_TIME_NS       60
`define FILTER_CYCLES        \
	((`FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Processor reset values.
`define ZERO_REG_RST         32'h00000000
`define PC_RST               32'h00000000
`define EXC_CAUSE_RST        32'h00000000
`define STATUS_WORD_RST      32'h00000020

// Port reset values.
`define PORT_DIR8_RST        8'hFF
`define PORT_DIR16_RST       16'hFFFF
`define PMC_CLEAR_RST        8'h00
`define PMC_PORT2_RST        8'h01
`define PMC_ADDR_LOW_RST     16'hFFFF
`define PMC_DATA_LOW_RST     16'hFFFF
`define PMC_ADDR_HIGH_RST    16'h01FF
`define PMC_CHIP_SEL_RST     8'h99
`define PMC_CONTROL_RST      8'h33
`define PMC_MEM_CTRL_RST     8'h1F
`define PMC_SDRAM_CTRL_RST   8'h0F
`define PFC_RST              8'h00

// Timer reset values.
`define TIMER_COUNT_RST      16'h0000
`define TIMER_MODE_CLEAR_RST 8'h00
`define CAP_MODE_SECOND_RST  8'h20

`endif

//--- rtl/rst_init_pkg.sv
package rst_init_pkg;

	// Phases of the reset sequence.
	typedef enum logic [1:0] {
		ST_HOLD,
		ST_LOAD,
		ST_RUN
	} rst_state_e;

	// Port configuration image loaded at reset.
	typedef struct packed {
		logic [7:0]  dir_p0;
		logic [7:0]  dir_p1;
		logic [7:0]  dir_p2;
		logic [7:0]  dir_p4;
		logic [7:0]  dir_p7;
		logic [7:0]  dir_cs;
		logic [7:0]  dir_ct;
		logic [7:0]  dir_cm;
		logic [7:0]  dir_cd;
		logic [7:0]  dir_bd;
		logic [15:0] dir_al;
		logic [15:0] dir_ah;
		logic [15:0] dir_dl;
		logic [7:0]  pmc_p0;
		logic [7:0]  pmc_p1;
		logic [7:0]  port2_mode_control;
		logic [7:0]  pmc_p4;
		logic [7:0]  dma_ack_port_mode_control;
		logic [15:0] address_low_mode_control;
		logic [15:0] data_low_mode_control;
		logic [15:0] address_high_mode_control;
		logic [7:0]  chip_select_port_mode_control;
		logic [7:0]  control_port_mode_control;
		logic [7:0]  memory_control_port_mode_control;
		logic [7:0]  sdram_control_port_mode_control;
		logic [7:0]  pfc_p0;
		logic [7:0]  pfc_p2;
		logic [7:0]  pfc_p4;
		logic [7:0]  sdram_port_function_control;
	} port_cfg_s;

	// Processor state image loaded at reset.
	typedef struct packed {
		logic [31:0] zero_register;
		logic [31:0] program_counter;
		logic [31:0] exception_cause_register;
		logic [31:0] processor_status_word;
	} cpu_init_s;

	// One capture timer image.
	typedef struct packed {
		logic [15:0] capture_timer_counter;
		logic [15:0] capture_compare_first;
		logic [15:0] capture_compare_second;
		logic [7:0]  capture_timer_mode_first;
		logic [7:0]  capture_timer_mode_second;
	} cap_timer_s;

	// One interval timer image.
	typedef struct packed {
		logic [15:0] interval_timer_counter;
		logic [15:0] interval_timer_compare;
		logic [7:0]  interval_timer_mode;
	} int_timer_s;

endpackage

//--- rtl/reset_glitch_filter.sv
`timescale 1ns/10ps
`include "rst_init_defs.svh"

// Synchronises the reset pin and accepts a new level only after it has
// stood stable for the filter time, so short glitches are rejected.
module reset_glitch_filter #(
	parameter int FILTER_LEN = `FILTER_CYCLES
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic clk_en,
	// Raw pin and filtered level.
	input  wire logic pin_n,
	output logic      level_n
);

	localparam int CW = $clog2(FILTER_LEN + 1);

	logic          sync1_ff;
	logic          sync2_ff;
	logic [CW-1:0] count_ff;
	logic          level_ff;

	// Two-stage synchroniser; the pin starts asserted.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			sync1_ff <= pin_n;
			sync2_ff <= sync1_ff;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			count_ff <= '0;
			level_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			if (sync2_ff == level_ff)
				count_ff <= '0;
			else if (count_ff == CW'(FILTER_LEN - 1))
			begin
				count_ff <= '0;
				level_ff <= sync2_ff;
			end
			else
				count_ff <= count_ff + 1'b1;
		end
	end

	assign level_n = level_ff;

endmodule

//--- rtl/system_reset_initializer.sv
// Operation
// - Low reset input puts whole device into defined reset state.
// - Reset input rising releases reset and processor starts executing.
// - Reset input filtered so glitches under about 60 ns are ignored.
// - During reset all pins float except clock output and supply pins.
// - Ports 0,1,2,4,7,BD read as inputs; bus ports take control role.
// - Zero register and program counter cleared, so execution starts at zero.
// - Exception cause register cleared to zero.
// - Processor status word loaded with 00000020H.
// - Saved-state registers and table base pointer left uninitialised.
// - Port output latches and internal RAM left uninitialised.
// - Port direction registers set to all ones, meaning input.
// - Mode control of ports 0,1,4,BD cleared; port 2 set to 01H.
// - Address-low, data-low mode FFFFH; address-high mode 01FFH.
// - Chip-select port mode 99H; control port mode 33H.
// - Memory-control port mode 1FH; SDRAM-control port mode 0FH.
// - All port function control registers cleared to zero.
// - Capture timer counters and capture/compare registers cleared.
// - Capture timer first mode 00H, second mode 20H.
// - Interval timer counters, compares and modes cleared.
`timescale 1ns/10ps
`include "rst_init_defs.svh"

module system_reset_initializer
	import rst_init_pkg::*;
#(
	parameter int N_CAP_TIMERS = 2,
	parameter int N_INT_TIMERS = 4
) (
	// Clock, asynchronous reset and clock enable.
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic clk_en,
	// Active-low reset pin from the external supervisor.
	input  wire logic reset_pin_n,
	// Chip-wide reset and processor start.
	output logic      sys_reset,
	output logic      cpu_run,
	output logic      init_load,
	output cpu_init_s cpu_init,
	// Pin control.
	output logic      pins_float,
	output logic      clock_output_pin_en,
	output logic      port_input_forced,
	output logic      port_control_forced,
	// Configuration images.
	output port_cfg_s port_cfg,
	output cap_timer_s [N_CAP_TIMERS-1:0] cap_timers,
	output int_timer_s [N_INT_TIMERS-1:0] int_timers
);

	logic       filt_n;
	rst_state_e state_ff;
	rst_state_e nxt_state;
	logic       sys_reset_ff;
	logic       run_ff;

	reset_glitch_filter #(
		.FILTER_LEN (`FILTER_CYCLES)
	) u_filter (
		.clk     (clk),
		.reset   (reset),
		.clk_en  (clk_en),
		.pin_n   (reset_pin_n),
		.level_n (filt_n)
	);

	// Sequence: hold and load images while low, wait one ST_LOAD cycle, then run.
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_HOLD:
				if (filt_n)
					nxt_state = ST_LOAD;
			ST_LOAD:
				nxt_state = filt_n ? ST_RUN : ST_HOLD;
			ST_RUN:
				if (!filt_n)
					nxt_state = ST_HOLD;
			default:
				nxt_state = ST_HOLD;
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			state_ff <= ST_HOLD;
		else if (clk_en)
			state_ff <= nxt_state;
	end

	// Registered reset and run flags so every consumer sees one edge.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sys_reset_ff <= 1'b1;
			run_ff       <= 1'b0;
		end
		else if (clk_en)
		begin
			sys_reset_ff <= (nxt_state == ST_HOLD);
			run_ff       <= (nxt_state == ST_RUN);
		end
	end

	assign sys_reset = sys_reset_ff;
	assign cpu_run   = run_ff;
	assign init_load = sys_reset_ff;

	assign pins_float          = sys_reset_ff;
	assign clock_output_pin_en = 1'b1; // Clock output keeps toggling.

	assign port_input_forced   = sys_reset_ff;
	assign port_control_forced = sys_reset_ff;

	// Processor start image; saved-state registers and base pointer are
	// deliberately absent since reset leaves them undefined.
	// saved state undefined
	always_comb
	begin
		cpu_init.zero_register            = `ZERO_REG_RST;
		cpu_init.program_counter          = `PC_RST;
		cpu_init.exception_cause_register = `EXC_CAUSE_RST;
		cpu_init.processor_status_word    = `STATUS_WORD_RST;
	end

	// Port configuration image; output latches and RAM get no value.
	// latches left undefined
	always_comb
	begin
		port_cfg.dir_p0 = `PORT_DIR8_RST;
		port_cfg.dir_p1 = `PORT_DIR8_RST;
		port_cfg.dir_p2 = `PORT_DIR8_RST;
		port_cfg.dir_p4 = `PORT_DIR8_RST;
		port_cfg.dir_p7 = `PORT_DIR8_RST;
		port_cfg.dir_cs = `PORT_DIR8_RST;
		port_cfg.dir_ct = `PORT_DIR8_RST;
		port_cfg.dir_cm = `PORT_DIR8_RST;
		port_cfg.dir_cd = `PORT_DIR8_RST;
		port_cfg.dir_bd = `PORT_DIR8_RST;
		port_cfg.dir_al = `PORT_DIR16_RST;
		port_cfg.dir_ah = `PORT_DIR16_RST;
		port_cfg.dir_dl = `PORT_DIR16_RST;
		port_cfg.pmc_p0                    = `PMC_CLEAR_RST;
		port_cfg.pmc_p1                    = `PMC_CLEAR_RST;
		port_cfg.pmc_p4                    = `PMC_CLEAR_RST;
		port_cfg.dma_ack_port_mode_control = `PMC_CLEAR_RST;
		port_cfg.port2_mode_control        = `PMC_PORT2_RST;
		port_cfg.address_low_mode_control  = `PMC_ADDR_LOW_RST;
		port_cfg.data_low_mode_control     = `PMC_DATA_LOW_RST;
		port_cfg.address_high_mode_control = `PMC_ADDR_HIGH_RST;
		port_cfg.chip_select_port_mode_control = `PMC_CHIP_SEL_RST;
		port_cfg.control_port_mode_control     = `PMC_CONTROL_RST;
		port_cfg.memory_control_port_mode_control = `PMC_MEM_CTRL_RST;
		port_cfg.sdram_control_port_mode_control  = `PMC_SDRAM_CTRL_RST;
		port_cfg.pfc_p0                      = `PFC_RST;
		port_cfg.pfc_p2                      = `PFC_RST;
		port_cfg.pfc_p4                      = `PFC_RST;
		port_cfg.sdram_port_function_control = `PFC_RST;
	end

	// Timer images, one entry per timer.
	always_comb
	begin
		for (int i = 0; i < N_CAP_TIMERS; i++)
		begin
			cap_timers[i].capture_timer_counter  = `TIMER_COUNT_RST;
			cap_timers[i].capture_compare_first  = `TIMER_COUNT_RST;
			cap_timers[i].capture_compare_second = `TIMER_COUNT_RST;
			cap_timers[i].capture_timer_mode_first  = `TIMER_MODE_CLEAR_RST;
			cap_timers[i].capture_timer_mode_second = `CAP_MODE_SECOND_RST;
		end
		for (int j = 0; j < N_INT_TIMERS; j++)
		begin
			int_timers[j].interval_timer_counter = `TIMER_COUNT_RST;
			int_timers[j].interval_timer_compare = `TIMER_COUNT_RST;
			int_timers[j].interval_timer_mode    = `TIMER_MODE_CLEAR_RST;
		end
	end

endmodule

//--- tb/system_reset_initializer_properties.sv
`timescale 1ns/10ps

// Checks the reset outputs against the pin; every check is disabled while the block reset is high.
module system_reset_initializer_properties
	import rst_init_pkg::*;
#(
	parameter int N_CAP_TIMERS = 2,
	parameter int N_INT_TIMERS = 4
) (
	input wire logic                     clk,
	input wire logic                     reset,
	input wire logic                     clk_en,
	input wire logic                     reset_pin_n,
	input wire logic                     sys_reset,
	input wire logic                     cpu_run,
	input wire logic                     init_load,
	input wire cpu_init_s                cpu_init,
	input wire logic                     pins_float,
	input wire logic                     clock_output_pin_en,
	input wire logic                     port_input_forced,
	input wire logic                     port_control_forced,
	input wire port_cfg_s                port_cfg,
	input wire cap_timer_s [N_CAP_TIMERS-1:0] cap_timers,
	input wire int_timer_s [N_INT_TIMERS-1:0] int_timers
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	chk_low_resets: assert property (
		(!reset_pin_n && clk_en)[*8] |-> sys_reset)
		else $error("long low pin did not reset");
	chk_run_excl: assert property (
		sys_reset |-> !cpu_run)
		else $error("processor runs in reset");
	chk_high_release: assert property (
		(reset_pin_n && clk_en)[*8] |-> ##1 !sys_reset)
		else $error("reset not released");
	chk_release_run: assert property (
		$fell(sys_reset) |-> ##[1:2] cpu_run)
		else $error("processor not started");
	chk_pins_float: assert property (
		pins_float == sys_reset)
		else $error("pin float differs from reset");
	chk_clock_running: assert property (
		clock_output_pin_en)
		else $error("clock output stopped");
	chk_port_roles: assert property (
		sys_reset |-> port_input_forced && port_control_forced)
		else $error("port roles not forced");
	chk_cpu_image: assert property (
		init_load |-> cpu_init == 128'h20)
		else $error("processor image wrong");
	chk_port_image: assert property (
		init_load |-> port_cfg.port2_mode_control == 8'h01
			&& port_cfg.address_high_mode_control == 16'h01FF)
		else $error("port image wrong");
	chk_timer_image: assert property (
		init_load |-> cap_timers[0] == 64'h20 && int_timers[0] == 40'h0)
		else $error("timer image wrong");
	chk_port_dirs: assert property (
		init_load |-> port_cfg.dir_p0 == 8'hFF && port_cfg.dir_al == 16'hFFFF)
		else $error("port directions wrong");
	chk_select_modes: assert property (
		init_load |-> port_cfg.chip_select_port_mode_control == 8'h99
			&& port_cfg.sdram_control_port_mode_control == 8'h0F)
		else $error("select modes wrong");
endmodule

bind system_reset_initializer system_reset_initializer_properties #(
	.N_CAP_TIMERS(N_CAP_TIMERS), .N_INT_TIMERS(N_INT_TIMERS)
) u_system_reset_initializer_properties (
	.clk(clk), .reset(reset), .clk_en(clk_en), .reset_pin_n(reset_pin_n),
	.sys_reset(sys_reset), .cpu_run(cpu_run), .init_load(init_load),
	.cpu_init(cpu_init), .pins_float(pins_float),
	.clock_output_pin_en(clock_output_pin_en),
	.port_input_forced(port_input_forced),
	.port_control_forced(port_control_forced), .port_cfg(port_cfg),
	.cap_timers(cap_timers), .int_timers(int_timers)
);

//--- tb/reset_supervisor.sv
`timescale 1ns/10ps

// External reset source driving the active-low pin.
module reset_supervisor #(
	parameter int STAB_CYCLES = 30
) (
	input  wire logic clk,
	input  wire logic hold_low,
	output logic      reset_pin_n
);
	int stab_cnt = STAB_CYCLES;

	always @(posedge clk)
	begin
		if (stab_cnt != 0)
			stab_cnt <= stab_cnt - 1;
	end

	// The pin stays low through power-up and whenever a reset is asked.
	assign reset_pin_n = !(hold_low || stab_cnt != 0);
endmodule

//--- tb/test_system_reset_initializer.sv
`timescale 1ns/10ps
`include "rst_init_defs.svh"

module test_system_reset_initializer;
	import rst_init_pkg::*;

	logic                clk = 1'b0;
	logic                reset = 1'b1;
	logic                clk_en = 1'b1;
	logic                hold_low = 1'b0;
	logic                reset_pin_n;
	logic                sys_reset;
	logic                cpu_run;
	logic                init_load;
	cpu_init_s           cpu_init;
	logic                pins_float;
	logic                clock_output_pin_en;
	logic                port_input_forced;
	logic                port_control_forced;
	port_cfg_s           port_cfg;
	cap_timer_s [1:0]    cap_timers;
	int_timer_s [3:0]    int_timers;
	int                  fail_count = 0;
	int                  checked = 0;
	int                  len;
	logic                seen;

	system_reset_initializer u_system_reset_initializer (
		.clk(clk), .reset(reset), .clk_en(clk_en), .reset_pin_n(reset_pin_n),
		.sys_reset(sys_reset), .cpu_run(cpu_run), .init_load(init_load),
		.cpu_init(cpu_init), .pins_float(pins_float),
		.clock_output_pin_en(clock_output_pin_en),
		.port_input_forced(port_input_forced),
		.port_control_forced(port_control_forced), .port_cfg(port_cfg),
		.cap_timers(cap_timers), .int_timers(int_timers)
	);

	reset_supervisor u_reset_supervisor (
		.clk(clk), .hold_low(hold_low), .reset_pin_n(reset_pin_n)
	);

	// Free-running 50 MHz clock.
	initial
	begin
		forever #10 clk = ~clk;
	end

	// Port image expected after reset.
	function automatic port_cfg_s exp_cfg();
		port_cfg_s c;
		c = '0;
		{c.dir_p0, c.dir_p1, c.dir_p2, c.dir_p4, c.dir_p7} = {5{8'hFF}};
		{c.dir_cs, c.dir_ct, c.dir_cm, c.dir_cd, c.dir_bd} = {5{8'hFF}};
		{c.dir_al, c.dir_ah, c.dir_dl} = {3{16'hFFFF}};
		c.port2_mode_control = 8'h01;
		c.address_low_mode_control = 16'hFFFF;
		c.data_low_mode_control = 16'hFFFF;
		c.address_high_mode_control = 16'h01FF;
		c.chip_select_port_mode_control = 8'h99;
		c.control_port_mode_control = 8'h33;
		c.memory_control_port_mode_control = 8'h1F;
		c.sdram_control_port_mode_control = 8'h0F;
		return c;
	endfunction

	// A low pulse resets once it lasts the whole filter time.
	function automatic logic exp_hit(input int n);
		return n >= `FILTER_CYCLES;
	endfunction

	task automatic check(input logic [299:0] got, input logic [299:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t mismatch got %0h exp %0h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		if (fail_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic pulse(input int n);
		@(posedge clk) hold_low <= 1'b1;
		repeat (n) @(posedge clk);
		hold_low <= 1'b0;
	endtask

	task automatic wait_run();
		int n;
		n = 0;
		while (cpu_run !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		#1;
		check(cpu_run, 1'b1);
		check(sys_reset, 1'b0);
		check({init_load, pins_float, port_input_forced}, 3'b000);
		check(port_control_forced, 1'b0);
	endtask

	// Guards against a hang.
	initial
	begin
		#200000;
		fail_count++;
		complete_run();
	end

	// Main sequence.
	initial
	begin
		void'($urandom(32'hE2A5310F));
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check(sys_reset, 1'b1);
		check(cpu_run, 1'b0);
		check(init_load, 1'b1);
		check({pins_float, clock_output_pin_en}, 2'b11);
		check({port_input_forced, port_control_forced}, 2'b11);
		check(cpu_init, 128'h20);
		check(port_cfg, exp_cfg());
		check(cap_timers, {2{64'h20}});
		check(int_timers, 160'h0);
		wait_run();
		// glitch length sweep, the two boundary lengths first
		for (int i = 0; i < 18; i++)
		begin
			len = (i < 2) ? `FILTER_CYCLES - 1 + i : $urandom_range(1, 10);
			pulse(len);
			seen = 1'b0;
			repeat (15)
			begin
				@(posedge clk);
				#1;
				seen |= sys_reset;
			end
			check(seen, exp_hit(len));
			wait_run();
		end
		@(posedge clk) clk_en <= 1'b0;
		pulse(10);
		repeat (5) @(posedge clk);
		#1;
		check(sys_reset, 1'b0);
		@(posedge clk) clk_en <= 1'b1;
		@(posedge clk) reset <= 1'b1;
		#1;
		check({sys_reset, cpu_run}, 2'b10);
		@(posedge clk) reset <= 1'b0;
		wait_run();
		complete_run();
	end
endmodule
